// file: hdl/hmic_fifo_mem.sv
`timescale 1ns/1ps
module hmic_fifo_mem
  import hmic_pkg::*;
(
  // Clock
  input  wire logic                    clk,
  // Write port
  input  wire logic                    wr_en,
  input  wire logic [HMIC_FIFO_AW-1:0] wr_addr,
  input  wire logic [31:0]             wr_data,
  // Read port
  input  wire logic                    rd_en,
  input  wire logic [HMIC_FIFO_AW-1:0] rd_addr,
  output logic      [31:0]             rd_data
);

  logic [31:0] mem [HMIC_FIFO_DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// file: hdl/hmic_swap.sv
`timescale 1ns/1ps
module hmic_swap
  import hmic_pkg::*;
(
  hmic_word_if.swap w
);

  logic [31:0] bit_rev;

  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_rev
      assign bit_rev[i] = w.raw[31-i];
    end
  endgenerate

  always_comb begin
    case (hmic_swap_t'(w.sel))
      HMIC_SWAP_NONE: w.swapped = w.raw; // R01
      HMIC_SWAP_HALF: w.swapped = {w.raw[15:0], w.raw[31:16]}; // R15
      HMIC_SWAP_BYTE: w.swapped = {w.raw[7:0], w.raw[15:8], w.raw[23:16], w.raw[31:24]}; // R15
      HMIC_SWAP_BIT:  w.swapped = bit_rev; // R15
      default:        w.swapped = w.raw;
    endcase
  end

endmodule

// file: hdl/hmic_top.sv
`timescale 1ns/1ps
// How it works
// R01: Swap select picks word, half, byte, bit
// R02: Auth mode latched on init, locked while busy
// R03: Algorithm latched on init, locked while busy
// R04: Long key latched with init and HMAC
// R05: Word counter counts pushes while not empty
// R06: Init or trigger write clears word counter
// R07: Not-empty flag shows input word held
// R08: Input write pushes old word, loads new
// R09: Input read returns held word, no side effect
// R10: Last-word field counts valid bits from top
// R11: Trigger write keeps last-word field unchanged
// R12: Trigger pads and starts digest over FIFO
// R13: Trigger bit always reads zero
// R14: Init resets core; reads as zero
// R15: Half, byte, bit swaps reorder the word
module hmic_top
  import hmic_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 srst,
  // AHB-lite register slave
  input  wire logic                 hsel,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [7:0]           haddr,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // Hash core side
  input  wire logic                 core_busy,
  input  wire logic                 core_word_ready,
  output logic                      core_word_valid,
  output logic      [31:0]          core_word_data,
  output logic                      core_init_pulse,
  output logic                      digest_start_pulse,
  output logic      [HMIC_LW_W-1:0] last_word_valid_bits,
  output logic                      algorithm_choice,
  output logic                      auth_mode_select,
  output logic                      long_key_flag
);

  function automatic hmic_reg_t reg_decode(input logic [7:0] a);
    case (a)
      HMIC_OFS_CTRL:  reg_decode = HMIC_REG_CTRL;
      HMIC_OFS_INPUT: reg_decode = HMIC_REG_INPUT;
      HMIC_OFS_START: reg_decode = HMIC_REG_START;
      default:        reg_decode = HMIC_REG_NONE;
    endcase
  endfunction

  // Bus phase tracking
  logic                    ph_valid_ff;
  logic                    ph_write_ff;
  logic [7:0]              ph_addr_ff;
  logic                    hreadyout_ff;
  logic [31:0]             hrdata_ff;
  // Register state
  logic [31:0]             input_word_ff;
  logic                    input_not_empty_ff;
  logic [HMIC_CNT_W-1:0]   pushed_word_count_ff;
  logic [HMIC_SWAP_W-1:0]  input_swap_select_ff;
  logic                    auth_mode_ff;
  logic                    algorithm_ff;
  logic                    long_key_ff;
  logic [HMIC_LW_W-1:0]    last_word_bits_ff;
  // FIFO and drain
  logic [HMIC_FIFO_AW:0]   wr_ptr_ff;
  logic [HMIC_FIFO_AW:0]   rd_ptr_ff;
  logic                    rd_pending_ff;
  logic                    word_valid_ff;
  logic [31:0]             word_data_ff;
  logic                    digest_pending_ff;
  logic                    init_pulse_ff;
  logic                    digest_pulse_ff;
  // Combinational
  logic                    accept;
  logic                    stall_req;
  logic                    exec_wr;
  hmic_reg_t               ph_reg;
  logic                    wr_ctrl;
  logic                    wr_input;
  logic                    wr_start;
  logic                    init_wr;
  logic                    trig_wr;
  logic                    push;
  logic                    rd_en;
  logic [HMIC_FIFO_AW:0]   fifo_cnt;
  logic                    calc_running;
  logic [31:0]             mem_rdata;

  hmic_word_if swp ();

  assign accept    = hsel && htrans[1] && hready;
  assign stall_req = accept && hwrite && fifo_cnt >= HMIC_FIFO_STALL_AT &&
                     (reg_decode(haddr) == HMIC_REG_INPUT || reg_decode(haddr) == HMIC_REG_START);
  assign exec_wr   = ph_valid_ff && ph_write_ff && hreadyout_ff;
  assign ph_reg    = reg_decode(ph_addr_ff);
  assign wr_ctrl   = exec_wr && ph_reg == HMIC_REG_CTRL;
  assign wr_input  = exec_wr && ph_reg == HMIC_REG_INPUT;
  assign wr_start  = exec_wr && ph_reg == HMIC_REG_START;
  assign init_wr   = wr_ctrl && hwdata[HMIC_CTRL_INIT_BIT];
  assign trig_wr   = wr_start && hwdata[HMIC_START_TRIG_BIT];
  // The held word enters the FIFO when replaced, or as the final word on a trigger.
  assign push      = (wr_input || trig_wr) && input_not_empty_ff; // R08
  assign fifo_cnt  = wr_ptr_ff - rd_ptr_ff;
  assign calc_running = core_busy || digest_pending_ff;
  assign rd_en     = (wr_ptr_ff != rd_ptr_ff) && !rd_pending_ff && !word_valid_ff && !init_wr;

  // Bus address phase capture.
  always_ff @(posedge clk) begin
    if (srst) begin
      ph_valid_ff <= 1'b0;
      ph_write_ff <= 1'b0;
      ph_addr_ff  <= 8'h00;
    end else if (hready) begin
      ph_valid_ff <= accept;
      ph_write_ff <= hwrite;
      ph_addr_ff  <= haddr;
    end
  end

  // Wait states keep one FIFO slot spare, so a push never meets a full FIFO.
  always_ff @(posedge clk) begin
    if (srst) begin
      hreadyout_ff <= 1'b1;
    end else if (!hreadyout_ff) begin
      hreadyout_ff <= fifo_cnt < HMIC_FIFO_STALL_AT;
    end else begin
      hreadyout_ff <= !stall_req;
    end
  end

  // Read data is taken in the address phase from the current register state.
  always_ff @(posedge clk) begin
    if (srst) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (accept && !hwrite) begin
      hrdata_ff <= 32'h0000_0000;
      case (reg_decode(haddr))
        HMIC_REG_CTRL: begin
          hrdata_ff[HMIC_CTRL_SWAP_LSB +: HMIC_SWAP_W] <= input_swap_select_ff;
          hrdata_ff[HMIC_CTRL_MODE_BIT]                <= auth_mode_ff;
          hrdata_ff[HMIC_CTRL_ALG_BIT]                 <= algorithm_ff;
          hrdata_ff[HMIC_CTRL_CNT_LSB +: HMIC_CNT_W]   <= pushed_word_count_ff; // R05
          hrdata_ff[HMIC_CTRL_NEMPT_BIT]               <= input_not_empty_ff; // R07
          hrdata_ff[HMIC_CTRL_LKEY_BIT]                <= long_key_ff; // R04
        end
        HMIC_REG_INPUT: hrdata_ff <= input_word_ff; // R09
        HMIC_REG_START: hrdata_ff[HMIC_START_LW_LSB +: HMIC_LW_W] <= last_word_bits_ff; // R13
        default:        hrdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Held input word and its not-empty flag.
  always_ff @(posedge clk) begin
    if (srst) begin
      input_word_ff      <= HMIC_INPUT_RST;
      input_not_empty_ff <= 1'b0;
    end else begin
      if (init_wr) begin
        input_word_ff <= HMIC_INPUT_RST; // R14
      end else if (wr_input) begin
        input_word_ff <= hwdata; // R08
      end
      if (init_wr || trig_wr) begin
        input_not_empty_ff <= 1'b0; // R07
      end else if (wr_input) begin
        input_not_empty_ff <= 1'b1; // R07
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pushed_word_count_ff <= 4'h0;
    end else if (init_wr || trig_wr) begin
      pushed_word_count_ff <= 4'h0; // R06
    end else if (wr_input && input_not_empty_ff) begin
      pushed_word_count_ff <= pushed_word_count_ff + 4'h1; // R05
    end
  end

  // Configuration; algorithm and mode only change at an init outside a calculation.
  always_ff @(posedge clk) begin
    if (srst) begin
      input_swap_select_ff <= HMIC_SWAP_RST;
      auth_mode_ff         <= 1'b0;
      algorithm_ff         <= 1'b0;
      long_key_ff          <= 1'b0;
    end else if (wr_ctrl) begin
      input_swap_select_ff <= hwdata[HMIC_CTRL_SWAP_LSB +: HMIC_SWAP_W]; // R01
      if (init_wr && !calc_running) begin
        auth_mode_ff <= hwdata[HMIC_CTRL_MODE_BIT]; // R02
        algorithm_ff <= hwdata[HMIC_CTRL_ALG_BIT]; // R03
        if (hwdata[HMIC_CTRL_MODE_BIT]) begin
          long_key_ff <= hwdata[HMIC_CTRL_LKEY_BIT]; // R04
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      last_word_bits_ff <= HMIC_LW_RST;
    end else if (wr_start && !hwdata[HMIC_START_TRIG_BIT]) begin
      last_word_bits_ff <= hwdata[HMIC_START_LW_LSB +: HMIC_LW_W]; // R11 R10
    end
  end

  // FIFO pointers; an init flushes everything not yet handed to the core.
  always_ff @(posedge clk) begin
    if (srst || init_wr) begin
      wr_ptr_ff <= '0; // R14
      rd_ptr_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 5'h01;
      end
      if (rd_en) begin
        rd_ptr_ff <= rd_ptr_ff + 5'h01;
      end
    end
  end

  hmic_fifo_mem u_mem (
    .clk     (clk),
    .wr_en   (push),
    .wr_addr (wr_ptr_ff[HMIC_FIFO_AW-1:0]),
    .wr_data (input_word_ff),
    .rd_en   (rd_en),
    .rd_addr (rd_ptr_ff[HMIC_FIFO_AW-1:0]),
    .rd_data (mem_rdata)
  );

  assign swp.raw = mem_rdata;
  assign swp.sel = input_swap_select_ff;

  hmic_swap u_swap (
    .w (swp)
  );

  // One word in flight at a time; at most one word every three cycles, so a back-to-back bus writer can outrun it.
  always_ff @(posedge clk) begin
    if (srst || init_wr) begin
      rd_pending_ff <= 1'b0;
      word_valid_ff <= 1'b0;
      word_data_ff  <= 32'h0000_0000;
    end else begin
      rd_pending_ff <= rd_en;
      if (rd_pending_ff) begin
        word_valid_ff <= 1'b1;
        word_data_ff  <= swp.swapped; // R01
      end else if (core_word_ready) begin
        word_valid_ff <= 1'b0;
      end
    end
  end

  // The start is held back until the core has taken every pushed word.
  always_ff @(posedge clk) begin
    if (srst || init_wr) begin
      digest_pending_ff <= 1'b0;
      digest_pulse_ff   <= 1'b0;
    end else begin
      digest_pulse_ff <= 1'b0;
      if (trig_wr) begin
        digest_pending_ff <= 1'b1; // R12
      end else if (digest_pending_ff && fifo_cnt == '0 && !rd_pending_ff && !word_valid_ff) begin
        digest_pending_ff <= 1'b0;
        digest_pulse_ff   <= 1'b1; // R12
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      init_pulse_ff <= 1'b0;
    end else begin
      init_pulse_ff <= init_wr; // R14
    end
  end

  assign hrdata               = hrdata_ff;
  assign hreadyout            = hreadyout_ff;
  assign hresp                = 1'b0;
  assign core_word_valid      = word_valid_ff;
  assign core_word_data       = word_data_ff;
  assign core_init_pulse      = init_pulse_ff;
  assign digest_start_pulse   = digest_pulse_ff;
  assign last_word_valid_bits = last_word_bits_ff;
  assign algorithm_choice     = algorithm_ff;
  assign auth_mode_select     = auth_mode_ff;
  assign long_key_flag        = long_key_ff;

endmodule

// file: inc/hmic_pkg.sv
package hmic_pkg;

  // Register byte offsets.
  localparam logic [7:0] HMIC_OFS_CTRL  = 8'h00;
  localparam logic [7:0] HMIC_OFS_INPUT = 8'h04;
  localparam logic [7:0] HMIC_OFS_START = 8'h08;

  // Control register field positions.
  localparam int HMIC_CTRL_INIT_BIT  = 2;
  localparam int HMIC_CTRL_SWAP_LSB  = 4;
  localparam int HMIC_CTRL_MODE_BIT  = 6;
  localparam int HMIC_CTRL_ALG_BIT   = 7;
  localparam int HMIC_CTRL_CNT_LSB   = 8;
  localparam int HMIC_CTRL_NEMPT_BIT = 12;
  localparam int HMIC_CTRL_LKEY_BIT  = 16;

  // Start register field positions.
  localparam int HMIC_START_LW_LSB   = 0;
  localparam int HMIC_START_TRIG_BIT = 8;

  // Field widths.
  localparam int HMIC_SWAP_W = 2;
  localparam int HMIC_CNT_W  = 4;
  localparam int HMIC_LW_W   = 5;

  // Reset values.
  localparam logic [31:0]          HMIC_INPUT_RST = 32'h0000_0000;
  localparam logic [HMIC_LW_W-1:0] HMIC_LW_RST    = 5'h00;
  localparam logic [HMIC_SWAP_W-1:0] HMIC_SWAP_RST = 2'h0;

  // Input FIFO geometry: one 512-bit block.
  localparam int              HMIC_FIFO_AW    = 4;
  localparam int              HMIC_FIFO_DEPTH = 16;
  localparam logic [HMIC_FIFO_AW:0] HMIC_FIFO_STALL_AT = 5'h0f;

  typedef enum logic [1:0] {
    HMIC_SWAP_NONE,
    HMIC_SWAP_HALF,
    HMIC_SWAP_BYTE,
    HMIC_SWAP_BIT
  } hmic_swap_t;

  typedef enum logic [1:0] {
    HMIC_REG_CTRL,
    HMIC_REG_INPUT,
    HMIC_REG_START,
    HMIC_REG_NONE
  } hmic_reg_t;

endpackage

// file: inc/hmic_word_if.sv
`timescale 1ns/1ps
interface hmic_word_if;
  logic [31:0] raw;
  logic [1:0]  sel;
  logic [31:0] swapped;

  modport ctrl (output raw, output sel, input swapped);
  modport swap (input raw, input sel, output swapped);
endinterface

// file: tb/hash_message_input_control_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; $display("mismatch %s exp %h got %h", n, e, g); end end
module hash_message_input_control_tb;
  import hmic_pkg::*;
  logic        clk = 0, srst = 1, hsel = 0, hwrite = 0, core_busy = 0, core_word_ready = 0, hready;
  logic [1:0]  htrans = 2'h0;
  logic [7:0]  haddr = 8'h00;
  logic [31:0] hwdata = 32'h0, held = 32'h0, w, q, hrdata, core_word_data;
  logic        hreadyout, hresp, core_word_valid, core_init_pulse, digest_start_pulse;
  logic        algorithm_choice, auth_mode_select, long_key_flag;
  logic [4:0]  last_word_valid_bits;
  logic [31:0] exq[$];
  int          fail_count = 0, checks = 0, seed = 8, ne = 0, cnt = 0, swp = 0, alg = 0, mode = 0, lkey = 0, lw, k;

  assign hready = hreadyout;
  always #2.5 clk = ~clk;

  hmic_top hmic_top_i (.clk, .srst, .hsel, .htrans, .hwrite, .haddr, .hwdata, .hready, .hrdata, .hreadyout,
    .hresp, .core_busy, .core_word_ready, .core_word_valid, .core_word_data, .core_init_pulse,
    .digest_start_pulse, .last_word_valid_bits, .algorithm_choice, .auth_mode_select, .long_key_flag);

  function automatic logic [31:0] swf(input logic [31:0] d, input int s);
    logic [31:0] r;
    r = d;
    if (s == 1) r = {d[15:0], d[31:16]};
    if (s == 2) r = {d[7:0], d[15:8], d[23:16], d[31:24]};
    if (s == 3) for (int i = 0; i < 32; i++) r[i] = d[31-i];
    return r;
  endfunction

  function automatic logic [31:0] cexp();
    return 32'(swp << 4 | mode << 6 | alg << 7 | cnt << 8 | ne << 12 | lkey << 16);
  endfunction

  task automatic finish_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // A write is held in its data phase until the slave stops stalling.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 400);
    q = hrdata;
    `CHK("hresp", 1'b0, hresp)
    if (n >= 400) begin
      fail_count++;
      finish_test();
    end
  endtask

  task automatic put(input logic [31:0] d);
    bus(1'b1, HMIC_OFS_INPUT, d);
    if (ne) begin
      exq.push_back(held);
      cnt = (cnt + 1) % 16;
    end
    held = d;
    ne = 1;
  endtask

  // The core stalls at random so that the word hold is exercised; at one write every three cycles the FIFO does not reach the stall level.
  always @(posedge clk) begin
    core_word_ready <= 1'($random(seed));
    if (core_word_valid === 1'b1 && core_word_ready === 1'b1) begin
      `CHK("queued", 1'b1, exq.size() > 0)
      if (exq.size() > 0) begin
        w = exq.pop_front();
        `CHK("word", swf(w, swp), core_word_data)
      end
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    bus(1'b0, HMIC_OFS_CTRL, 32'h0);
    `CHK("ctrl_rst", 32'h0, q)
    bus(1'b0, HMIC_OFS_INPUT, 32'h0);
    `CHK("input_rst", 32'h0, q)
    bus(1'b0, HMIC_OFS_START, 32'h0);
    `CHK("start_rst", 32'h0, q)
    bus(1'b0, 8'h3c, 32'h0);
    `CHK("unmapped", 32'h0, q)
    for (int s = 0; s < 4; s++) begin
      swp = s;
      mode = s & 1;
      alg = s >> 1;
      if (mode) lkey = 1;
      bus(1'b1, HMIC_OFS_CTRL, 32'(4 | s << 4 | mode << 6 | alg << 7 | 1 << 16));
      held = 32'h0;
      ne = 0;
      cnt = 0;
      // The write lands at the edge the task returns on, so look one edge later.
      @(posedge clk);
      `CHK("init_pulse", 1'b1, core_init_pulse)
      `CHK("alg", 1'(alg), algorithm_choice)
      `CHK("mode", 1'(mode), auth_mode_select)
      `CHK("lkey", 1'(lkey), long_key_flag)
      bus(1'b0, HMIC_OFS_INPUT, 32'h0);
      `CHK("input_init", 32'h0, q)
      for (int j = 0; j < 2 + 5 * s; j++) put($random(seed));
      bus(1'b0, HMIC_OFS_CTRL, 32'h0);
      `CHK("ctrl", cexp(), q)
      bus(1'b0, HMIC_OFS_INPUT, 32'h0);
      `CHK("held", held, q)
      lw = $random(seed) & 31;
      bus(1'b1, HMIC_OFS_START, 32'(lw));
      bus(1'b0, HMIC_OFS_START, 32'h0);
      `CHK("start", 32'(lw), q)
      bus(1'b1, HMIC_OFS_START, 32'(32'h100 | ~lw & 31));
      exq.push_back(held);
      ne = 0;
      cnt = 0;
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (digest_start_pulse !== 1'b1 && k < 1000);
      `CHK("start_wait", 1'b1, k < 1000)
      if (k >= 1000) begin
        finish_test();
      end
      `CHK("drained", 0, exq.size())
      `CHK("lw_out", 5'(lw), last_word_valid_bits)
      bus(1'b0, HMIC_OFS_START, 32'h0);
      `CHK("trig_rd", 32'(lw), q)
      bus(1'b0, HMIC_OFS_CTRL, 32'h0);
      `CHK("ctrl_clr", cexp(), q)
    end
    @(posedge clk);
    core_busy <= 1'b1;
    bus(1'b1, HMIC_OFS_CTRL, 32'h4);
    @(posedge clk);
    `CHK("alg_busy", 1'(alg), algorithm_choice)
    `CHK("mode_busy", 1'(mode), auth_mode_select)
    core_busy <= 1'b0;
    finish_test();
  end
endmodule

// file: tb/hmic_assertions.sv
`timescale 1ns/1ps
module hmic_assertions
  import hmic_pkg::*;
(
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 srst,
  // Bus and core side
  input wire logic [31:0]          hwdata,
  input wire logic                 core_busy,
  input wire logic                 core_word_ready,
  input wire logic                 core_word_valid,
  input wire logic [31:0]          core_word_data,
  input wire logic                 core_init_pulse,
  input wire logic                 digest_start_pulse,
  input wire logic [HMIC_LW_W-1:0] last_word_valid_bits,
  input wire logic                 algorithm_choice,
  input wire logic                 auth_mode_select,
  input wire logic                 long_key_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  chk_init_pulse_one: assert property (core_init_pulse |=> !core_init_pulse)
    else $error("init pulse longer than one cycle");
  chk_start_pulse_one: assert property (digest_start_pulse |=> !digest_start_pulse)
    else $error("digest start pulse longer than one cycle");
  chk_word_hold: assert property (core_word_valid && !core_word_ready |=>
    core_init_pulse || (core_word_valid && $stable(core_word_data)))
    else $error("presented word changed before it was taken");
  chk_init_drops: assert property (core_init_pulse |-> !core_word_valid [*2])
    else $error("word presented right after init");
  chk_alg_locked: assert property (core_busy |=> $stable(algorithm_choice))
    else $error("algorithm changed while core busy");
  chk_mode_on_init: assert property ($changed(auth_mode_select) |-> core_init_pulse)
    else $error("mode changed without init");
  chk_lkey_hmac: assert property ($changed(long_key_flag) |-> core_init_pulse && auth_mode_select)
    else $error("long key changed outside hmac init");
  chk_lw_no_trig: assert property ($changed(last_word_valid_bits) |-> !$past(hwdata[8]))
    else $error("last word bits changed by trigger write");

  // Main scenarios, to see that the pulse and word-hold antecedents are reached.
  cov_start: cover property (digest_start_pulse);
  cov_init: cover property (core_init_pulse);
  cov_stall: cover property (core_word_valid && !core_word_ready);
endmodule

bind hmic_top hmic_assertions hmic_assertions_i (.clk, .srst, .hwdata, .core_busy, .core_word_ready,
  .core_word_valid, .core_word_data, .core_init_pulse, .digest_start_pulse, .last_word_valid_bits,
  .algorithm_choice, .auth_mode_select, .long_key_flag);
